/* core/wwdt_pkg.sv */
`default_nettype none
package wwdt_pkg;

   // ************************************************************
   // Register map (index, byte address is four times the index)
   // ************************************************************
   localparam int unsigned IDX_W = 2;
   localparam logic [IDX_W-1:0] REG_IDX_CTRL = 2'h0;
   localparam logic [IDX_W-1:0] REG_IDX_STATUS = 2'h1;
   localparam logic [IDX_W-1:0] REG_IDX_GUARD = 2'h2;
   localparam int unsigned ADDR_IDX_LSB = 2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;

   // ************************************************************
   // Field layout and reset values
   // ************************************************************
   localparam int unsigned REG_W = 8;
   localparam int unsigned CODE_W = 4;
   localparam int unsigned PERIOD_LSB = 0;
   localparam int unsigned WINDOW_LSB = 4;
   localparam int unsigned LOCK_BIT = 7;
   localparam int unsigned BUSY_BIT = 0;
   localparam logic [REG_W-1:0] CTRL_RESET = 8'h00;
   localparam logic [CODE_W-1:0] CODE_OFF = 4'h0;
   localparam logic [CODE_W-1:0] CODE_FIRST = 4'h1;
   localparam logic [CODE_W-1:0] CODE_MAX = 4'hB;

   // ************************************************************
   // Timing
   // ************************************************************
   localparam int unsigned OSC_FREQ_HZ = 1000;
   localparam int unsigned MIN_TIMEOUT_MS = 8;
   localparam int unsigned CNT_W = 14;
   localparam logic [CNT_W-1:0] MIN_TIMEOUT_TICKS = CNT_W'(MIN_TIMEOUT_MS * OSC_FREQ_HZ / 1000);
   localparam logic [CNT_W-1:0] CNT_ONE = 14'h0001;
   localparam logic [CNT_W-1:0] CNT_ZERO = 14'h0000;
   localparam int unsigned GUARD_W = 3;
   localparam logic [GUARD_W-1:0] GUARD_TRANSFERS = 3'h4;

   typedef enum logic [2:0] {
      ST_OFF,
      ST_NORMAL,
      ST_FIRST,
      ST_CLOSED,
      ST_OPEN
   } wwdt_state_e;

   // Ticks of one timeout for a period or window code
   function automatic logic [CNT_W-1:0] timeout_ticks(input logic [CODE_W-1:0] code);
      logic [CODE_W-1:0] c;
      c = (code > CODE_MAX) ? CODE_MAX : code;
      if (c == CODE_OFF) begin
         return CNT_ZERO;
      end
      return MIN_TIMEOUT_TICKS << (c - CODE_FIRST);
   endfunction : timeout_ticks

endpackage : wwdt_pkg
`default_nettype wire

/* core/wwdt_ahb_slave.sv */
`default_nettype none
module wwdt_ahb_slave (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic [wwdt_pkg::REG_W-1:0] rd_data,
   output logic [wwdt_pkg::IDX_W-1:0] rd_idx,
   output logic wr_en,
   output logic [wwdt_pkg::IDX_W-1:0] wr_idx,
   output logic [wwdt_pkg::REG_W-1:0] wr_data,
   output logic xfer
);

   // ************************************************************
   // Address phase decode
   // ************************************************************
   wire logic addr_phase;
   wire logic mapped;
   assign addr_phase = hsel & htrans[1] & hready;
   assign rd_idx = haddr[wwdt_pkg::ADDR_IDX_LSB +: wwdt_pkg::IDX_W];
   assign mapped = (haddr[31:wwdt_pkg::ADDR_IDX_LSB+wwdt_pkg::IDX_W] == '0)
                 & (haddr[wwdt_pkg::ADDR_IDX_LSB-1:0] == '0)
                 & (rd_idx <= wwdt_pkg::REG_IDX_GUARD)
                 & (hsize == wwdt_pkg::HSIZE_WORD);

   logic dp_valid;
   logic dp_write;
   logic dp_mapped;
   logic [wwdt_pkg::IDX_W-1:0] dp_idx;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_mapped <= 1'b0;
         dp_idx <= '0;
         hrdata <= '0;
      end else begin
         dp_valid <= addr_phase;
         dp_write <= hwrite;
         dp_mapped <= mapped;
         dp_idx <= rd_idx;
         // Read data captured at the address phase, zero when unmapped
         if (addr_phase & !hwrite) begin
            hrdata <= mapped ? {24'h000000, rd_data} : 32'h00000000;
         end
      end
   end

   // Zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign wr_en = dp_valid & dp_write & dp_mapped;
   assign wr_idx = dp_idx;
   assign wr_data = hwdata[wwdt_pkg::REG_W-1:0];
   assign xfer = dp_valid;

endmodule : wwdt_ahb_slave
`default_nettype wire

/* core/wwdt_guard.sv */
`default_nettype none
module wwdt_guard (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic key_hit,
   input wire logic xfer,
   input wire logic consume,
   output logic open_window
);

   logic [wwdt_pkg::GUARD_W-1:0] left;

   // Key opens a window of a few bus transfers; any guarded write closes it
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         left <= '0;
      end else if (key_hit) begin
         left <= wwdt_pkg::GUARD_TRANSFERS;
      end else if (consume) begin
         left <= '0;
      end else if (xfer && open_window) begin
         left <= left - 3'h1;
      end
   end

   assign open_window = (left != '0);

endmodule : wwdt_guard
`default_nettype wire

/* core/wwdt_top.sv */
// Added by the designer: the AHB-Lite register port and the register addresses.
`default_nettype none
// Function
// - Enabled watchdog pulses system reset when no restart arrives before timeout.
// - Counter advances on rising edges of the one kilohertz watchdog oscillator clock.
// - Eleven timeout lengths, eight milliseconds to eight seconds, set by period field.
// - Non-zero period enables the watchdog; zero period keeps it disabled.
// - Accepted restart clears the counter and starts a fresh timeout.
// - Window field zero means normal mode, non-zero selects window mode.
// - Restart during closed period in window mode requests system reset.
// - Open period follows closed period; restart accepted only while open.
// - After window enable or debug exit, closed period waits for first restart.
// - Counter runs in run-time debug, halts and clears during debug halt.
// - Resuming from halt in window mode runs one normal timeout first.
// - Control bits and lock change only through the timed guard procedure.
// - While lock is one, control register writes are ignored.
// - Software sets lock only; clearing lock works only in debug mode.
// - Control resets from boot fuse; enabled fuse also sets lock.
// - Period and window writes cross to watchdog timing with busy flag.
// - Counting continues in every mode where the oscillator runs, except debug halt and disabled (period zero), which hold the counter at zero.
// - Four bit codes 1 to 11 give 8 to 8192 ticks, doubling.
// - Busy set at boot and by an accepted guarded, unlocked control write, cleared by hardware on the next tick.
module wwdt_top #(
   parameter logic [wwdt_pkg::REG_W-1:0] GUARD_KEY = 8'hA5 // Value is arbitrary
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic watchdog_osc_clock,
   input wire logic watchdog_restart_instr,
   input wire logic cpu_debug_halt,
   input wire logic debug_mode,
   input wire logic [wwdt_pkg::REG_W-1:0] boot_watchdog_fuse,
   output logic system_reset_req
);

   // ************************************************************
   // Bus slave
   // ************************************************************
   logic [wwdt_pkg::REG_W-1:0] rd_data;
   logic [wwdt_pkg::IDX_W-1:0] rd_idx;
   logic wr_en;
   logic [wwdt_pkg::IDX_W-1:0] wr_idx;
   logic [wwdt_pkg::REG_W-1:0] wr_data;
   logic xfer;

   wwdt_ahb_slave u_bus (
      .clk(clk),
      .rst_n(rst_n),
      .hsel(hsel),
      .haddr(haddr),
      .htrans(htrans),
      .hwrite(hwrite),
      .hsize(hsize),
      .hready(hready),
      .hwdata(hwdata),
      .hreadyout(hreadyout),
      .hresp(hresp),
      .hrdata(hrdata),
      .rd_data(rd_data),
      .rd_idx(rd_idx),
      .wr_en(wr_en),
      .wr_idx(wr_idx),
      .wr_data(wr_data),
      .xfer(xfer)
   );

   // ************************************************************
   // Configuration change guard
   // ************************************************************
   wire logic wr_ctrl_any;
   wire logic wr_status_any;
   wire logic key_hit;
   wire logic guard_open;
   wire logic guard_consume;

   assign wr_ctrl_any = wr_en & (wr_idx == wwdt_pkg::REG_IDX_CTRL);
   assign wr_status_any = wr_en & (wr_idx == wwdt_pkg::REG_IDX_STATUS);
   assign key_hit = wr_en & (wr_idx == wwdt_pkg::REG_IDX_GUARD) & (wr_data == GUARD_KEY);
   assign guard_consume = (wr_ctrl_any | wr_status_any) & guard_open;

   wwdt_guard u_guard (
      .clk(clk),
      .rst_n(rst_n),
      .key_hit(key_hit),
      .xfer(xfer),
      .consume(guard_consume),
      .open_window(guard_open)
   );

   // ************************************************************
   // Register write qualification
   // ************************************************************
   logic [wwdt_pkg::REG_W-1:0] ctrl;
   logic lock;
   logic busy;
   logic boot_done;

   wire logic wr_ctrl_ok;
   wire logic lock_set;
   wire logic lock_clear;
   wire logic lock_wr_bit;

   // Unguarded or locked writes leave the control register alone
   assign wr_ctrl_ok = wr_ctrl_any & guard_open & !lock;
   assign lock_wr_bit = wr_data[wwdt_pkg::LOCK_BIT];
   assign lock_set = wr_status_any & guard_open & lock_wr_bit;
   assign lock_clear = wr_status_any & guard_open & !lock_wr_bit & debug_mode;

   // ************************************************************
   // Oscillator tick
   // ************************************************************
   // Oscillator level is sampled on clk; its rising edge is one tick
   logic osc_q;
   wire logic tick;
   assign tick = watchdog_osc_clock & !osc_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_q <= 1'b0;
      end else begin
         osc_q <= watchdog_osc_clock;
      end
   end

   // ************************************************************
   // Software-visible registers
   // ************************************************************
   wire logic [wwdt_pkg::CODE_W-1:0] fuse_period;
   wire logic apply_cfg;
   assign fuse_period = boot_watchdog_fuse[wwdt_pkg::PERIOD_LSB +: wwdt_pkg::CODE_W];
   // Transfer completes on the first tick after the write
   assign apply_cfg = busy & tick & boot_done;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_done <= 1'b0;
      end else begin
         boot_done <= 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= wwdt_pkg::CTRL_RESET;
      end else if (!boot_done) begin
         ctrl <= boot_watchdog_fuse;
      end else if (wr_ctrl_ok) begin
         ctrl <= wr_data;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lock <= 1'b0;
      end else if (!boot_done) begin
         lock <= (fuse_period != wwdt_pkg::CODE_OFF);
      end else if (lock_set) begin
         lock <= 1'b1;
      end else if (lock_clear) begin
         lock <= 1'b0;
      end
   end

   // Set wins over the hardware clear
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         busy <= 1'b0;
      end else if (!boot_done || wr_ctrl_ok) begin
         busy <= 1'b1;
      end else if (apply_cfg) begin
         busy <= 1'b0;
      end
   end

   // ************************************************************
   // Status word
   // ************************************************************
   // Fixed bit positions; every other bit reads zero
   logic [wwdt_pkg::REG_W-1:0] status_word;

   always_comb begin
      status_word = '0;
      status_word[wwdt_pkg::LOCK_BIT] = lock;
      status_word[wwdt_pkg::BUSY_BIT] = busy;
   end

   // ************************************************************
   // Read mux
   // ************************************************************
   // Key register is write only, so it reads zero
   wire logic sel_ctrl;
   wire logic sel_status;
   assign sel_ctrl = (rd_idx == wwdt_pkg::REG_IDX_CTRL);
   assign sel_status = (rd_idx == wwdt_pkg::REG_IDX_STATUS);
   assign rd_data = sel_ctrl ? ctrl :
                    sel_status ? status_word : '0;

   // ************************************************************
   // Active configuration on the timing side
   // ************************************************************
   logic [wwdt_pkg::CODE_W-1:0] act_period;
   logic [wwdt_pkg::CODE_W-1:0] act_window;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         act_period <= wwdt_pkg::CODE_OFF;
         act_window <= wwdt_pkg::CODE_OFF;
      end else if (apply_cfg) begin
         act_period <= ctrl[wwdt_pkg::PERIOD_LSB +: wwdt_pkg::CODE_W];
         act_window <= ctrl[wwdt_pkg::WINDOW_LSB +: wwdt_pkg::CODE_W];
      end
   end

   wire logic [wwdt_pkg::CODE_W-1:0] cfg_period;
   wire logic [wwdt_pkg::CODE_W-1:0] cfg_window;
   wire logic [wwdt_pkg::CNT_W-1:0] open_last;
   wire logic [wwdt_pkg::CNT_W-1:0] closed_last;
   wire logic cfg_enabled;
   wire logic cfg_window_mode;

   assign cfg_period = apply_cfg ? ctrl[wwdt_pkg::PERIOD_LSB +: wwdt_pkg::CODE_W] : act_period;
   assign cfg_window = apply_cfg ? ctrl[wwdt_pkg::WINDOW_LSB +: wwdt_pkg::CODE_W] : act_window;
   assign cfg_enabled = (cfg_period != wwdt_pkg::CODE_OFF);
   assign cfg_window_mode = (cfg_window != wwdt_pkg::CODE_OFF);
   assign open_last = wwdt_pkg::timeout_ticks(act_period) - wwdt_pkg::CNT_ONE;
   assign closed_last = wwdt_pkg::timeout_ticks(act_window) - wwdt_pkg::CNT_ONE;

   // ************************************************************
   // Timeout state machine
   // ************************************************************
   wwdt_pkg::wwdt_state_e state;
   wwdt_pkg::wwdt_state_e next_state;
   wwdt_pkg::wwdt_state_e base_state;
   logic [wwdt_pkg::CNT_W-1:0] cnt;
   logic [wwdt_pkg::CNT_W-1:0] next_cnt;
   logic next_fire;

   wire logic open_hit;
   wire logic closed_hit;
   wire logic restart;
   assign open_hit = tick & (cnt == open_last);
   assign closed_hit = tick & (cnt == closed_last);
   assign restart = watchdog_restart_instr;

   // Window mode starts with a normal timeout until the first restart
   always_comb begin
      base_state = wwdt_pkg::ST_OFF;
      if (cfg_enabled) begin
         base_state = cfg_window_mode ? wwdt_pkg::ST_FIRST : wwdt_pkg::ST_NORMAL;
      end
   end

   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_fire = 1'b0;
      if (cpu_debug_halt) begin
         next_state = base_state;
         next_cnt = wwdt_pkg::CNT_ZERO;
      end else if (apply_cfg) begin
         next_state = base_state;
         next_cnt = wwdt_pkg::CNT_ZERO;
      end else begin
         case (state)
            wwdt_pkg::ST_OFF: begin
               next_cnt = wwdt_pkg::CNT_ZERO;
            end
            wwdt_pkg::ST_NORMAL: begin
               if (restart) begin
                  next_cnt = wwdt_pkg::CNT_ZERO;
               end else if (open_hit) begin
                  next_fire = 1'b1;
                  next_cnt = wwdt_pkg::CNT_ZERO;
               end else if (tick) begin
                  next_cnt = cnt + wwdt_pkg::CNT_ONE;
               end
            end
            wwdt_pkg::ST_FIRST: begin
               if (restart) begin
                  next_state = wwdt_pkg::ST_CLOSED;
                  next_cnt = wwdt_pkg::CNT_ZERO;
               end else if (open_hit) begin
                  next_fire = 1'b1;
                  next_cnt = wwdt_pkg::CNT_ZERO;
               end else if (tick) begin
                  next_cnt = cnt + wwdt_pkg::CNT_ONE;
               end
            end
            wwdt_pkg::ST_CLOSED: begin
               if (restart) begin
                  next_fire = 1'b1;
                  next_state = wwdt_pkg::ST_FIRST;
                  next_cnt = wwdt_pkg::CNT_ZERO;
               end else if (closed_hit) begin
                  next_state = wwdt_pkg::ST_OPEN;
                  next_cnt = wwdt_pkg::CNT_ZERO;
               end else if (tick) begin
                  next_cnt = cnt + wwdt_pkg::CNT_ONE;
               end
            end
            wwdt_pkg::ST_OPEN: begin
               if (restart) begin
                  next_state = wwdt_pkg::ST_CLOSED;
                  next_cnt = wwdt_pkg::CNT_ZERO;
               end else if (open_hit) begin
                  next_fire = 1'b1;
                  next_state = wwdt_pkg::ST_FIRST;
                  next_cnt = wwdt_pkg::CNT_ZERO;
               end else if (tick) begin
                  next_cnt = cnt + wwdt_pkg::CNT_ONE;
               end
            end
            default: begin
               next_state = wwdt_pkg::ST_OFF;
               next_cnt = wwdt_pkg::CNT_ZERO;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= wwdt_pkg::ST_OFF;
         cnt <= wwdt_pkg::CNT_ZERO;
         system_reset_req <= 1'b0;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         system_reset_req <= next_fire;
      end
   end

endmodule : wwdt_top
`default_nettype wire

/* dv/wwdt_top_asserts.sv */
`default_nettype none
module wwdt_top_asserts (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic watchdog_osc_clock,
   input wire logic watchdog_restart_instr,
   input wire logic cpu_debug_halt,
   input wire logic debug_mode,
   input wire logic [7:0] boot_watchdog_fuse,
   input wire logic system_reset_req
);
   timeunit 1ns;
   timeprecision 1ps;
   logic osc_q;
   wire tick = watchdog_osc_clock && !osc_q;
   wire rd_addr = hsel && htrans[1] && hready && !hwrite;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         osc_q <= 1'b0;
      end else begin
         osc_q <= watchdog_osc_clock;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   sequence s_quiet2; !system_reset_req ##1 !system_reset_req; endsequence
   property p_pulse_width; system_reset_req |=> !system_reset_req; endproperty
   a_pulse_width: assert property (p_pulse_width) else $error("reset pulse too long");
   property p_pulse_cause; system_reset_req |-> $past(tick) || $past(watchdog_restart_instr); endproperty
   a_pulse_cause: assert property (p_pulse_cause) else $error("reset pulse without cause");
   property p_halt_quiet; $past(cpu_debug_halt) |-> !system_reset_req; endproperty
   a_halt_quiet: assert property (p_halt_quiet) else $error("reset pulse during halt");
   property p_halt_exit; $fell(cpu_debug_halt) |-> s_quiet2; endproperty
   a_halt_exit: assert property (p_halt_exit) else $error("reset pulse at halt exit");
   property p_boot_quiet; $rose(rst_n) |-> s_quiet2; endproperty
   a_boot_quiet: assert property (p_boot_quiet) else $error("reset pulse at boot");
   property p_bus_okay; hreadyout && !hresp; endproperty
   a_bus_okay: assert property (p_bus_okay) else $error("bus not ready or error");
   property p_rdata_hold; !$past(rd_addr) |-> $stable(hrdata); endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed");
   property p_rdata_upper; hrdata[31:8] == 24'h000000; endproperty
   a_rdata_upper: assert property (p_rdata_upper) else $error("read data upper bits set");
endmodule : wwdt_top_asserts

bind wwdt_top wwdt_top_asserts wwdt_top_asserts_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .watchdog_osc_clock(watchdog_osc_clock),
   .watchdog_restart_instr(watchdog_restart_instr), .cpu_debug_halt(cpu_debug_halt), .debug_mode(debug_mode),
   .boot_watchdog_fuse(boot_watchdog_fuse), .system_reset_req(system_reset_req));
`default_nettype wire

/* dv/wwdt_cpu_model.sv */
`default_nettype none
module wwdt_cpu_model #(
   parameter int OSC_HALF = 2
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic osc_run,
   input wire logic restart_go,
   output logic watchdog_osc_clock,
   output logic watchdog_restart_instr
);
   timeunit 1ns;
   timeprecision 1ps;
   int div;
   // Stopped source keeps its level, as a gated oscillator would
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         div <= 0;
         watchdog_osc_clock <= 1'b0;
         watchdog_restart_instr <= 1'b0;
      end else begin
         watchdog_restart_instr <= restart_go;
         if (osc_run) begin
            div <= (div == OSC_HALF - 1) ? 0 : div + 1;
            watchdog_osc_clock <= (div == OSC_HALF - 1) ? ~watchdog_osc_clock : watchdog_osc_clock;
         end
      end
   end
endmodule : wwdt_cpu_model
`default_nettype wire

/* dv/windowed_watchdog_timer_tb.sv */
`default_nettype none
module windowed_watchdog_timer_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] KEY = 8'h5C; // Arbitrary value
   localparam int TP = 4;
   logic clk, rst_n, hsel, hwrite, hreadyout, hresp, go, osc_run, osc, restart;
   logic cpu_debug_halt, debug_mode, system_reset_req;
   logic [7:0] fuse;
   logic [1:0] htrans;
   logic [31:0] haddr, hwdata, hrdata, rd;
   int mismatches, checks, n;
   wwdt_top #(.GUARD_KEY(KEY)) wwdt_top_i (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(wwdt_pkg::HSIZE_WORD), .hready(hreadyout), .hwdata(hwdata),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .watchdog_osc_clock(osc),
      .watchdog_restart_instr(restart), .cpu_debug_halt(cpu_debug_halt), .debug_mode(debug_mode),
      .boot_watchdog_fuse(fuse), .system_reset_req(system_reset_req));
   wwdt_cpu_model #(.OSC_HALF(TP / 2)) wwdt_cpu_model_i (.clk(clk), .rst_n(rst_n), .osc_run(osc_run),
      .restart_go(go), .watchdog_osc_clock(osc), .watchdog_restart_instr(restart));
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic rng(input int lo, input int hi);
      chk(32'(n >= lo && n <= hi), 32'h1);
   endtask : rng
   task automatic xfer(input logic [31:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= 2'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic gw(input logic [31:0] a, input logic [7:0] d);
      xfer(32'h8, 1'b1, KEY);
      xfer(a, 1'b1, d);
   endtask : gw
   task automatic wait_idle;
      for (int i = 0; i < 40; i++) begin
         xfer(32'h4, 1'b0, 8'h00);
         if (rd[0] === 1'b0) break;
      end
   endtask : wait_idle
   task automatic kick;
      @(posedge clk);
      go <= 1'b1;
      @(posedge clk);
      go <= 1'b0;
   endtask : kick
   task automatic wait_pulse(input int lim);
      n = 0;
      while (system_reset_req !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
   endtask : wait_pulse
   task automatic t_boot;
      wait_idle();
      xfer(32'h0, 1'b0, 8'h00);
      chk(rd, 32'h01);
      xfer(32'h4, 1'b0, 8'h00);
      chk(rd, 32'h80);
      kick();
      wait_pulse(100);
      rng(8 * TP - 4, 8 * TP + 4);
      $display("test boot done");
   endtask : t_boot
   task automatic t_lock;
      gw(32'h0, 8'h00);
      xfer(32'h0, 1'b0, 8'h00);
      chk(rd, 32'h01);
      xfer(32'h10, 1'b1, 8'hFF);
      xfer(32'h10, 1'b0, 8'h00);
      chk(rd, 32'h0);
      debug_mode <= 1'b1;
      xfer(32'h4, 1'b1, 8'h00);
      xfer(32'h4, 1'b0, 8'h00);
      chk(rd & 32'h80, 32'h80);
      gw(32'h4, 8'h00);
      xfer(32'h4, 1'b0, 8'h00);
      chk(rd & 32'h80, 32'h0);
      debug_mode <= 1'b0;
      gw(32'h4, 8'h80);
      gw(32'h4, 8'h00);
      xfer(32'h4, 1'b0, 8'h00);
      chk(rd & 32'h80, 32'h80);
      debug_mode <= 1'b1;
      gw(32'h4, 8'h00);
      debug_mode <= 1'b0;
      $display("test lock done");
   endtask : t_lock
   task automatic t_codes;
      for (int c = 11; c >= 0; c--) begin
         osc_run <= 1'b0;
         gw(32'h0, 8'(c));
         xfer(32'h4, 1'b0, 8'h00);
         chk(rd & 32'h1, 32'h1);
         osc_run <= 1'b1;
         wait_idle();
         xfer(32'h0, 1'b0, 8'h00);
         chk(rd, 32'(c));
         if (c >= 1 && c <= 4) begin
            kick();
            repeat ((8 << (c - 1)) * TP / 2) @(posedge clk);
            kick();
            wait_pulse(300);
            rng((8 << (c - 1)) * TP - 4, (8 << (c - 1)) * TP + 4);
         end
      end
      kick();
      wait_pulse(300);
      chk(32'(n), 32'd300);
      $display("test codes done");
   endtask : t_codes
   task automatic t_window;
      xfer(32'h0, 1'b1, 8'h22);
      xfer(32'h0, 1'b0, 8'h00);
      chk(rd, 32'h0);
      gw(32'h0, 8'h11);
      wait_idle();
      wait_pulse(100);
      rng(8 * TP - 8, 8 * TP + 4);
      kick();
      repeat (8) @(posedge clk);
      kick();
      wait_pulse(8);
      rng(0, 4);
      kick();
      repeat (8 * TP + 8) @(posedge clk);
      kick();
      wait_pulse(200);
      rng(16 * TP - 4, 16 * TP + 4);
      $display("test window done");
   endtask : t_window
   task automatic t_debug;
      repeat (20) @(posedge clk);
      cpu_debug_halt <= 1'b1;
      wait_pulse(100);
      chk(32'(n), 32'd100);
      cpu_debug_halt <= 1'b0;
      wait_pulse(100);
      rng(8 * TP - 4, 8 * TP + 4);
      gw(32'h0, 8'h01);
      wait_idle();
      kick();
      repeat (8) @(posedge clk);
      kick();
      wait_pulse(100);
      rng(8 * TP - 4, 8 * TP + 4);
      $display("test debug done");
   endtask : t_debug
   task automatic t_fuse;
      fuse <= 8'h00;
      rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      wait_idle();
      xfer(32'h0, 1'b0, 8'h00);
      chk(rd, 32'h0);
      xfer(32'h4, 1'b0, 8'h00);
      chk(rd, 32'h0);
      kick();
      wait_pulse(100);
      chk(32'(n), 32'd100);
      $display("test fuse done");
   endtask : t_fuse
   task automatic results;
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : results
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      results();
   end
   initial begin
      {rst_n, hsel, hwrite, go, cpu_debug_halt, debug_mode} = 6'h00;
      fuse = 8'h01;
      osc_run = 1'b1;
      htrans = 2'h0;
      haddr = 32'h0;
      hwdata = 32'h0;
      mismatches = 0;
      checks = 0;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      t_boot();
      t_lock();
      t_codes();
      t_window();
      t_debug();
      t_fuse();
      results();
   end
endmodule : windowed_watchdog_timer_tb
`default_nettype wire
